// file: core/hwd_watchdog.v
// Purpose: hardware watchdog with key restart and selectable timeout
// Assumes: CLK_IN is the oscillator; a machine cycle is 12 clocks
// Notes:   registers reached over AXI4-Lite, byte data in bits 7:0
`timescale 1ns/1ps
`include "hwd_map.vh"

module hwd_watchdog (
    // clock and reset
    input  wire        CLK_IN,
    input  wire        SYS_RST_IN,
    // power state
    input  wire        POWERDOWN_REQUEST_IN,
    input  wire        WAKE_PIN_N_IN,
    // reset pin and oscillator drive
    output reg         RST_PIN_OUT,
    output reg         OSC_RUN_OUT,
    // axi write address
    input  wire [11:0] S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    // axi write data
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    // axi write response
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    // axi read address
    input  wire [11:0] S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    // axi read data
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    localparam PW_RUN   = 2'd0;
    localparam PW_DOWN  = 2'd1;
    localparam PW_WAKE  = 2'd2;

    reg [1:0]              pw_state_r;
    reg [1:0]              pw_state_nxt;
    reg                    enabled_r;
    reg [`HWD_CNT_W-1:0]   watchdog_counter_r;
    reg [`HWD_MCYC_W-1:0]  mcyc_r;
    reg [2:0]              timeout_sel_r;
    reg [`HWD_CNT_W-1:0]   limit;
    reg                    overflow_r;
    reg [`HWD_ADDR_W-1:0]  aw_addr_r;
    reg                    aw_have_r;
    reg [7:0]              w_byte_r;
    reg                    w_lane0_r;
    reg                    w_have_r;
    reg                    key_wr;
    reg                    sel_wr;
    reg                    wr_hit;

    wire                   key_ok;
    wire                   key_armed;
    wire                   pulse;
    wire                   osc_running;
    wire                   mcyc_tick;
    wire                   int_rst;

    assign int_rst     = SYS_RST_IN || overflow_r;
    assign osc_running = (pw_state_r == PW_RUN);
    assign mcyc_tick   = osc_running && (mcyc_r == `HWD_CLKS_PER_MCYCLE - 1);

    // --------------------------------------------------------------
    // power-down tracking
    // --------------------------------------------------------------
    always @* begin
        pw_state_nxt = pw_state_r;
        case (pw_state_r)
            PW_RUN: begin
                if (POWERDOWN_REQUEST_IN)
                    pw_state_nxt = PW_DOWN;
            end
            PW_DOWN: begin
                if (!WAKE_PIN_N_IN)
                    pw_state_nxt = PW_WAKE;
            end
            PW_WAKE: begin
                // oscillator restarted, count held until pin release
                if (WAKE_PIN_N_IN)
                    pw_state_nxt = PW_RUN;
            end
            default: pw_state_nxt = PW_RUN;
        endcase
    end

    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            pw_state_r  <= PW_RUN;
            OSC_RUN_OUT <= 1'b1;
        end else begin
            pw_state_r  <= pw_state_nxt;
            OSC_RUN_OUT <= (pw_state_nxt != PW_DOWN);
        end
    end

    // --------------------------------------------------------------
    // timeout limit
    // --------------------------------------------------------------
    always @* begin
        limit = {`HWD_CNT_W{1'b0}};
        limit[`HWD_BASE_BITS-1:0] = {`HWD_BASE_BITS{1'b1}};
        case (timeout_sel_r)
            3'd1: limit[14]    = 1'b1;
            3'd2: limit[15:14] = 2'b11;
            3'd3: limit[16:14] = 3'b111;
            3'd4: limit[17:14] = 4'hF;
            3'd5: limit[18:14] = 5'h1F;
            3'd6: limit[19:14] = 6'h3F;
            3'd7: limit[20:14] = 7'h7F;
            default: limit[20:14] = 7'h00;
        endcase
    end

    // --------------------------------------------------------------
    // counter
    // --------------------------------------------------------------
    always @(posedge CLK_IN) begin
        if (int_rst) begin
            enabled_r          <= 1'b0;
            watchdog_counter_r <= `HWD_CNT_ZERO;
            mcyc_r             <= {`HWD_MCYC_W{1'b0}};
            overflow_r         <= 1'b0;
        end else begin
            if (osc_running)
                mcyc_r <= mcyc_tick ? {`HWD_MCYC_W{1'b0}} : mcyc_r + 1'b1;
            if (key_ok) begin
                enabled_r          <= 1'b1;
                watchdog_counter_r <= `HWD_CNT_ZERO;
            end else if (enabled_r && mcyc_tick) begin
                if (watchdog_counter_r == limit)
                    overflow_r <= 1'b1;
                else
                    watchdog_counter_r <= watchdog_counter_r + 1'b1;
            end
        end
    end

    always @(posedge CLK_IN) begin
        if (SYS_RST_IN)
            RST_PIN_OUT <= 1'b0;
        else
            RST_PIN_OUT <= pulse;
    end

    // --------------------------------------------------------------
    // bus write side
    // --------------------------------------------------------------
    always @* begin
        wr_hit = aw_have_r && w_have_r && !S_AXI_BVALID;
        key_wr = wr_hit && w_lane0_r && aw_addr_r == `HWD_ADDR_RESTART_KEY;
        sel_wr = wr_hit && w_lane0_r && aw_addr_r == `HWD_ADDR_TIMEOUT_SEL;
    end

    always @(posedge CLK_IN) begin
        if (int_rst) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_addr_r     <= {`HWD_ADDR_W{1'b0}};
            w_byte_r      <= 8'h00;
            w_lane0_r     <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `HWD_RESP_OKAY;
            timeout_sel_r <= `HWD_SEL_RESET;
        end else begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            if (!aw_have_r && S_AXI_AWVALID && !S_AXI_AWREADY) begin
                S_AXI_AWREADY <= 1'b1;
            end
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            if (!w_have_r && S_AXI_WVALID && !S_AXI_WREADY) begin
                S_AXI_WREADY <= 1'b1;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_r  <= 1'b1;
                w_byte_r  <= S_AXI_WDATA[7:0];
                w_lane0_r <= S_AXI_WSTRB[0];
            end
            if (wr_hit) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (aw_addr_r == `HWD_ADDR_RESTART_KEY ||
                                 aw_addr_r == `HWD_ADDR_TIMEOUT_SEL) ? `HWD_RESP_OKAY : `HWD_RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
            // reserved upper bits never stored
            if (sel_wr)
                timeout_sel_r <= w_byte_r[`HWD_SEL_MSB:`HWD_SEL_LSB];
        end
    end

    // --------------------------------------------------------------
    // bus read side
    // --------------------------------------------------------------
    always @(posedge CLK_IN) begin
        if (int_rst) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= `HWD_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= 1'b0;
            if (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID)
                S_AXI_ARREADY <= 1'b1;
            // data only after the address handshake, never alongside it
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RDATA   <= 32'h0000_0000;
                S_AXI_RRESP   <= `HWD_RESP_OKAY;
                S_AXI_RVALID  <= 1'b1;
                case (S_AXI_ARADDR)
                    // key register reads zero: write-only
                    `HWD_ADDR_RESTART_KEY: S_AXI_RDATA <= 32'h0000_0000;
                    `HWD_ADDR_TIMEOUT_SEL: S_AXI_RDATA[2:0] <= timeout_sel_r;
                    `HWD_ADDR_STATUS: begin
                        S_AXI_RDATA[`HWD_STAT_ENABLED_BIT] <= enabled_r;
                        S_AXI_RDATA[`HWD_STAT_ARMED_BIT]   <= key_armed;
                    end
                    default: S_AXI_RRESP <= `HWD_RESP_SLVERR;
                endcase
            end
            if (S_AXI_RVALID && S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // sub-blocks
    // --------------------------------------------------------------
    hwd_key_seq u_key (
        .clk_in     (CLK_IN),
        .rst_in     (int_rst),
        .wr_in      (key_wr),
        .data_in    (w_byte_r),
        .key_ok_out (key_ok),
        .armed_out  (key_armed)
    );

    // pulse counter is not cleared by its own overflow reset
    hwd_reset_pulse u_pulse (
        .clk_in    (CLK_IN),
        .rst_in    (SYS_RST_IN),
        .fire_in   (overflow_r),
        .pulse_out (pulse)
    );
endmodule // hwd_watchdog

// file: core/hwd_map.vh
// Purpose: constants for the hardware watchdog block
// Assumes: byte-wide special-function registers on an AXI4-Lite word bus
// Notes:   registers are byte-indexed, one per word, so byte address = 4 x index
`ifndef HWD_MAP_VH
`define HWD_MAP_VH

// --------------------------------------------------------------
// register indices and byte addresses
// --------------------------------------------------------------
`define HWD_IDX_RESTART_KEY    8'hA6
`define HWD_IDX_TIMEOUT_SEL    8'hA7
`define HWD_IDX_STATUS         8'hA8
`define HWD_ADDR_RESTART_KEY   12'h0298
`define HWD_ADDR_TIMEOUT_SEL   12'h029C
`define HWD_ADDR_STATUS        12'h02A0
`define HWD_ADDR_W             12

// --------------------------------------------------------------
// keys, fields, reset values
// --------------------------------------------------------------
`define HWD_KEY_FIRST          8'h1E
`define HWD_KEY_SECOND         8'hE1
`define HWD_SEL_LSB            0
`define HWD_SEL_MSB            2
`define HWD_SEL_RESET          3'h0
`define HWD_STAT_ENABLED_BIT   0
`define HWD_STAT_ARMED_BIT     1
`define HWD_BASE_BITS          14
`define HWD_PRE_BITS           7
`define HWD_CNT_W              21
`define HWD_CNT_ZERO           21'h00_0000

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define HWD_CLKS_PER_MCYCLE    12
`define HWD_MCYC_W             4
`define HWD_PULSE_OSC_PERIODS  7'h60
`define HWD_PULSE_W            7
`define HWD_RESP_OKAY          2'b00
`define HWD_RESP_SLVERR        2'b10

`endif

// file: core/hwd_key_seq.v
// Purpose: two-byte restart key sequence detector
// Assumes: wr_in is a one-cycle strobe with the written byte
// Notes:   any byte but the two keys abandons a half-finished sequence
`timescale 1ns/1ps
`include "hwd_map.vh"

module hwd_key_seq (
    // clock and reset
    input  wire       clk_in,
    input  wire       rst_in,
    // write strobe
    input  wire       wr_in,
    input  wire [7:0] data_in,
    // result
    output reg        key_ok_out,
    output reg        armed_out
);
    always @(posedge clk_in) begin
        if (rst_in) begin
            armed_out  <= 1'b0;
            key_ok_out <= 1'b0;
        end else begin
            key_ok_out <= 1'b0;
            if (wr_in) begin
                if (armed_out && data_in == `HWD_KEY_SECOND) begin
                    key_ok_out <= 1'b1;
                    armed_out  <= 1'b0;
                end else begin
                    // a repeated first key re-arms rather than abandons
                    armed_out <= (data_in == `HWD_KEY_FIRST);
                end
            end
        end
    end
endmodule // hwd_key_seq

// file: core/hwd_reset_pulse.v
// Purpose: stretches one overflow into a fixed reset pulse
// Assumes: clock runs at oscillator rate
// Notes:   a new trigger during the pulse restarts nothing
`timescale 1ns/1ps
`include "hwd_map.vh"

module hwd_reset_pulse (
    // clock and reset
    input  wire clk_in,
    input  wire rst_in,
    // trigger
    input  wire fire_in,
    // pulse
    output reg  pulse_out
);
    reg [`HWD_PULSE_W-1:0] left_r;

    always @(posedge clk_in) begin
        if (rst_in) begin
            left_r    <= {`HWD_PULSE_W{1'b0}};
            pulse_out <= 1'b0;
        end else if (fire_in && left_r == {`HWD_PULSE_W{1'b0}}) begin
            left_r    <= `HWD_PULSE_OSC_PERIODS - 7'h01;
            pulse_out <= 1'b1;
        end else if (left_r != {`HWD_PULSE_W{1'b0}}) begin
            left_r    <= left_r - 1'b1;
            pulse_out <= 1'b1;
        end else begin
            pulse_out <= 1'b0;
        end
    end
endmodule // hwd_reset_pulse

// file: tb/hwd_watchdog_monitor.sv
// Purpose: port-level checker for the hardware watchdog
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to hwd_watchdog at the foot of this file
`timescale 1ns/1ps
module hwd_watchdog_monitor (
    input wire       CLK_IN,
    input wire       SYS_RST_IN,
    input wire       POWERDOWN_REQUEST_IN,
    input wire       WAKE_PIN_N_IN,
    input wire       RST_PIN_OUT,
    input wire       OSC_RUN_OUT,
    input wire       S_AXI_AWVALID,
    input wire       S_AXI_AWREADY,
    input wire       S_AXI_WVALID,
    input wire       S_AXI_WREADY,
    input wire [1:0] S_AXI_BRESP,
    input wire       S_AXI_BVALID,
    input wire       S_AXI_BREADY,
    input wire       S_AXI_ARVALID,
    input wire       S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire       S_AXI_RVALID,
    input wire       S_AXI_RREADY
);
    // ------------------------------------------------------
    // pulse length helper and properties
    // ------------------------------------------------------
    reg [7:0] hi_len_r;
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN || !RST_PIN_OUT) hi_len_r <= 8'h00;
        else if (hi_len_r != 8'hFF) hi_len_r <= hi_len_r + 8'h01;
    end
    default clocking mon_cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    sequence wr_offer;
        S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
    endsequence
    sequence wr_take;
        (S_AXI_AWREADY && S_AXI_WREADY) ##1 (!S_AXI_AWREADY && !S_AXI_WREADY) ##1 S_AXI_BVALID;
    endsequence
    sequence rd_offer;
        S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
    endsequence
    sequence rd_take;
        (S_AXI_ARREADY && !S_AXI_RVALID) ##1 (!S_AXI_ARREADY && S_AXI_RVALID);
    endsequence
    pulse_len_a: assert property ($fell(RST_PIN_OUT) |-> hi_len_r == 8'h60)
        else $error("reset pin pulse length wrong");
    pulse_max_a: assert property (hi_len_r <= 8'h60)
        else $error("reset pin pulse too long");
    reset_idle_a: assert property ($fell(SYS_RST_IN) |-> !RST_PIN_OUT && OSC_RUN_OUT && !S_AXI_BVALID
        && !S_AXI_RVALID)
        else $error("outputs not idle after reset");
    write_answer_a: assert property (wr_offer |=> wr_take)
        else $error("write handshake timing wrong");
    read_answer_a: assert property (rd_offer |=> rd_take)
        else $error("read answer late");
    bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    pd_stop_a: assert property (POWERDOWN_REQUEST_IN && !RST_PIN_OUT |-> ##[1:2] !OSC_RUN_OUT)
        else $error("oscillator kept running in power-down");
    osc_hold_a: assert property (!OSC_RUN_OUT && WAKE_PIN_N_IN |=> !OSC_RUN_OUT)
        else $error("oscillator left power-down without wake");
    wake_osc_a: assert property (!OSC_RUN_OUT && !WAKE_PIN_N_IN |-> ##[1:2] OSC_RUN_OUT)
        else $error("low wake pin did not restart oscillator");
endmodule // hwd_watchdog_monitor

bind hwd_watchdog hwd_watchdog_monitor mon_u (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .POWERDOWN_REQUEST_IN(POWERDOWN_REQUEST_IN), .WAKE_PIN_N_IN(WAKE_PIN_N_IN), .RST_PIN_OUT(RST_PIN_OUT),
    .OSC_RUN_OUT(OSC_RUN_OUT), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY));

// file: tb/hwd_watchdog_bench.sv
// Purpose: self-checking bench for the hardware watchdog
// Assumes: full base timeout is run, about 220k clocks
// Notes:   hung waits are cut by the watchdog process
`timescale 1ns/1ps
`include "hwd_map.vh"
module hwd_watchdog_bench;
    reg         clk_in = 1'b0;
    reg         rst = 1'b1, pd = 1'b0, wake_n = 1'b1;
    reg  [11:0] awaddr = 12'h000, araddr = 12'h000;
    reg  [31:0] wdata = 32'h0000_0000;
    reg  [3:0]  wstrb = 4'h0;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire        rst_pin, osc_run, awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    integer     errors = 0, tests_run = 0, cyc, i;
    reg  [31:0] d;
    reg  [1:0]  r;
    localparam integer BASE = `HWD_CLKS_PER_MCYCLE * ((1 << `HWD_BASE_BITS) - 1);
    localparam integer FROZEN = 1202;

    hwd_watchdog dut_u (.CLK_IN(clk_in), .SYS_RST_IN(rst), .POWERDOWN_REQUEST_IN(pd), .WAKE_PIN_N_IN(wake_n),
        .RST_PIN_OUT(rst_pin), .OSC_RUN_OUT(osc_run), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    initial begin
        forever #20 clk_in = ~clk_in;
    end
    // ------------------------------------------------------
    // bus tasks and compares
    // ------------------------------------------------------
    task automatic axi_wr(input [11:0] a, input [7:0] v, input [3:0] s, output [1:0] resp);
        reg aw_done, w_done;
        begin
            aw_done = 1'b0;
            w_done = 1'b0;
            @(posedge clk_in);
            awaddr <= a; wdata <= {24'h00_0000, v}; wstrb <= s;
            awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
            do begin
                @(posedge clk_in);
                if (awready) begin aw_done = 1'b1; awvalid <= 1'b0; end
                if (wready) begin w_done = 1'b1; wvalid <= 1'b0; end
            end while (!(aw_done && w_done));
            while (!bvalid) @(posedge clk_in);
            resp = bresp;
            bready <= 1'b0;
        end
    endtask
    task automatic axi_rd(input [11:0] a, output [31:0] v, output [1:0] resp);
        begin
            @(posedge clk_in);
            araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
            do begin
                @(posedge clk_in);
                if (arready) arvalid <= 1'b0;
            end while (!rvalid);
            v = rdata; resp = rresp;
            rready <= 1'b0;
        end
    endtask
    task automatic chk(input string n, input [31:0] e, input [31:0] g);
        tests_run++;
        if (g !== e) begin errors++; $display("mismatch %s expected %h seen %h", n, e, g); end
    endtask
    task automatic chk_in(input string n, input integer lo, input integer hi, input integer g);
        tests_run++;
        if (g < lo || g > hi) begin errors++; $display("mismatch %s expected %0d..%0d seen %0d", n, lo, hi, g); end
    endtask
    task automatic wr(input [11:0] a, input [7:0] v);
        begin axi_wr(a, v, 4'h1, r); chk("write resp", `HWD_RESP_OKAY, r); end
    endtask
    task automatic rd_chk(input [11:0] a, input [7:0] e);
        begin axi_rd(a, d, r); chk("read resp", `HWD_RESP_OKAY, r); chk("read data", {24'h00_0000, e}, d); end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        repeat (240000) @(posedge clk_in);
        errors++;
        $display("mismatch watchdog expected finish seen hang");
        end_of_test;
    end
    // ------------------------------------------------------
    // test sequence
    // ------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_in);
        rst <= 1'b0;
        rd_chk(`HWD_ADDR_TIMEOUT_SEL, 8'h00);
        rd_chk(`HWD_ADDR_RESTART_KEY, 8'h00);
        rd_chk(`HWD_ADDR_STATUS, 8'h00);
        axi_rd(12'h0100, d, r);
        chk("unmapped read resp", `HWD_RESP_SLVERR, r);
        chk("unmapped read data", 32'h0000_0000, d);
        axi_wr(12'h0104, `HWD_KEY_FIRST, 4'h1, r);
        chk("unmapped write", `HWD_RESP_SLVERR, r);
        for (i = 0; i < 8; i++) begin
            wr(`HWD_ADDR_TIMEOUT_SEL, {5'b11111, i[2:0]});
            rd_chk(`HWD_ADDR_TIMEOUT_SEL, {5'b00000, i[2:0]});
        end
        wr(`HWD_ADDR_TIMEOUT_SEL, 8'h00);
        axi_wr(`HWD_ADDR_TIMEOUT_SEL, 8'h05, 4'h0, r);
        chk("strobe write resp", `HWD_RESP_OKAY, r);
        rd_chk(`HWD_ADDR_TIMEOUT_SEL, 8'h00);
        $display("test registers done");
        wr(`HWD_ADDR_RESTART_KEY, `HWD_KEY_FIRST);
        rd_chk(`HWD_ADDR_STATUS, 8'h02);
        wr(`HWD_ADDR_RESTART_KEY, 8'h55);
        wr(`HWD_ADDR_RESTART_KEY, `HWD_KEY_SECOND);
        rd_chk(`HWD_ADDR_STATUS, 8'h00);
        wr(`HWD_ADDR_RESTART_KEY, `HWD_KEY_FIRST);
        wr(`HWD_ADDR_RESTART_KEY, `HWD_KEY_SECOND);
        rd_chk(`HWD_ADDR_STATUS, 8'h01);
        wr(`HWD_ADDR_RESTART_KEY, 8'h00);
        wr(`HWD_ADDR_RESTART_KEY, `HWD_KEY_FIRST);
        wr(`HWD_ADDR_RESTART_KEY, 8'h00);
        rd_chk(`HWD_ADDR_STATUS, 8'h01);
        $display("test key sequence done");
        cyc = 0;
        // periodic service well inside the base timeout
        repeat (2) begin
            repeat (10000) begin @(posedge clk_in); if (rst_pin !== 1'b0) cyc++; end
            wr(`HWD_ADDR_RESTART_KEY, `HWD_KEY_FIRST);
            wr(`HWD_ADDR_RESTART_KEY, `HWD_KEY_SECOND);
        end
        chk("early reset pin", 32'h0000_0000, cyc);
        // power-down in mid-count shifts the overflow by the frozen span
        pd <= 1'b1;
        @(posedge clk_in);
        pd <= 1'b0;
        repeat (1000) @(posedge clk_in);
        chk("osc in power-down", 32'h0000_0000, {31'h0, osc_run});
        wake_n <= 1'b0;
        repeat (200) @(posedge clk_in);
        chk("osc on wake low", 32'h0000_0001, {31'h0, osc_run});
        wake_n <= 1'b1;
        cyc = FROZEN;
        while (rst_pin !== 1'b1 && cyc < 250000) begin @(posedge clk_in); cyc++; end
        chk_in("overflow time", BASE + FROZEN - 48, BASE + FROZEN + 48, cyc);
        cyc = 0;
        while (rst_pin === 1'b1 && cyc < 200) begin @(posedge clk_in); cyc++; end
        chk("pulse length", `HWD_PULSE_OSC_PERIODS, cyc);
        rd_chk(`HWD_ADDR_STATUS, 8'h00);
        rd_chk(`HWD_ADDR_TIMEOUT_SEL, 8'h00);
        $display("test overflow done");
        end_of_test;
    end
endmodule // hwd_watchdog_bench
